// ---- src/buck_converter_control_regs.sv ----
// Purpose: control and configuration registers of the step-down converter
// Assumes: special-function-register bus on the system clock, sync active-high reset
// Notes:   oscillator and shunt-hold inputs come from the analog side and are synchronised
`default_nettype none
// Notes on behaviour
// RULE_01: source bit clear uses local oscillator, set uses the system clock path.
// RULE_02: divide field matters only while the system clock is the source.
// RULE_03: divide codes 00..11 divide the system clock by 1, 2, 4, 8.
// RULE_04: invert bit inverts the system clock before the divider.
// RULE_05: with sync on, SAR clock inverted when polarity bit 0; ignored otherwise.
// RULE_06: sync bit places tracking in the quiet interval, aligns SAR clock.
// RULE_07: software clears the ADC SAR divider before enabling sync.
// RULE_08: pulse width code 00 disables skipping; others give 10, 20, 40 ns.
// RULE_09: status bit reads 1 while the shunt switch is closed.
// RULE_10: voltage code gives 1.8 V plus 0.1 V per step; 0111 gives 2.5 V.
// RULE_11: oscillator disable bit stops the local oscillator.
// RULE_12: switch size 00 smallest, 11 largest; 01 and 10 never written.
// RULE_13: shunt closed when forced, otherwise only while automatic hold holds it.
// RULE_14: control resets to pulse code 11; configuration to voltage 0001, size 11.
module buck_converter_control_regs
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  output var  logic [7:0]          sfr_rdata,
  input  wire logic                osc_clk_in,
  input  wire logic                forced_shunt_enable,
  input  wire logic                auto_shunt_hold,
  input  wire logic [7:0]          duty_request,
  output var  logic                conv_clk,
  output var  logic                conv_tick,
  output var  logic                osc_enable,
  output var  logic                adc_sync_enable,
  output var  logic                adc_sar_clk,
  output var  logic                adc_track_window,
  output var  logic                pulse_skip,
  output var  logic [8:0]          target_cv,
  output var  logic [1:0]          switch_size_select,
  output var  logic                shunt_close
);
  import buck_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [6:0] cfg;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_prev;
    logic       hold_s1;
    logic       hold_s2;
    logic [7:0] rdata;
    logic       conv_clk;
    logic       conv_tick;
    logic       osc_enable;
    logic       adc_sync;
    logic       sar_clk;
    logic       track;
    logic       skip;
    logic [8:0] target_cv;
    logic       shunt;
  } regs_s;

  regs_s st;
  regs_s next_st;

  conv_clk_if cif ();

  conv_clock_gen u_gen
  (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  function automatic logic [8:0] vout_cv(input logic [3:0] code);
    // codes above the top defined one are held at the top target
    if (code > VOUT_TOP_CODE)
      vout_cv = VOUT_BASE_CV + VOUT_STEP_CV * {5'h0, VOUT_TOP_CODE};
    else
      vout_cv = VOUT_BASE_CV + VOUT_STEP_CV * {5'h0, code};
  endfunction

  function automatic logic [2:0] mpw_cycles(input logic [1:0] code);
    case (code)
      MPW_10:  mpw_cycles = MPW1_CYC;
      MPW_20:  mpw_cycles = MPW2_CYC;
      default: mpw_cycles = MPW3_CYC;
    endcase
  endfunction

  // divider settings to the clock generator
  assign cif.ce      = ce;
  assign cif.div_sel = st.ctrl[CTRL_DIV_HI:CTRL_DIV_LO];
  assign cif.invert  = st.ctrl[CTRL_INV_BIT];

  logic       src_sys;
  logic       sync_on;
  logic       osc_level;
  logic       next_level;
  logic [1:0] mpw;

  assign src_sys   = st.ctrl[CTRL_SRC_BIT];
  assign sync_on   = st.ctrl[CTRL_SYNC_BIT];
  assign mpw       = st.ctrl[CTRL_MPW_HI:CTRL_MPW_LO];
  assign osc_level = st.osc_s2 & ~st.cfg[CFG_LOCAL_OSC_DISABLE_BIT]; // see RULE_11

  // register writes, reads and converter control outputs
  always_comb
  begin
    next_st = st;
    next_st.osc_s1   = osc_clk_in;
    next_st.osc_s2   = st.osc_s1;
    next_st.osc_prev = st.osc_s2;
    next_st.hold_s1  = auto_shunt_hold;
    next_st.hold_s2  = st.hold_s1;
    if (sfr_wr && hit(sfr_addr, ADDR_CONTROL))
      next_st.ctrl = sfr_wdata;
    if (sfr_wr && hit(sfr_addr, ADDR_CONFIG))
    begin
      next_st.cfg[CFG_VOUT_HI:CFG_LOCAL_OSC_DISABLE_BIT] = sfr_wdata[CFG_VOUT_HI:CFG_LOCAL_OSC_DISABLE_BIT];
      // reserved switch codes are dropped so the switches never sit half-sized
      if (sfr_wdata[CFG_SW_HI:CFG_SW_LO] == SW_MIN || sfr_wdata[CFG_SW_HI:CFG_SW_LO] == SW_MAX)
        next_st.cfg[CFG_SW_HI:CFG_SW_LO] = sfr_wdata[CFG_SW_HI:CFG_SW_LO]; // see RULE_12
    end
    if (sfr_rd)
    begin
      if (hit(sfr_addr, ADDR_CONTROL))
        next_st.rdata = st.ctrl;
      else if (hit(sfr_addr, ADDR_CONFIG))
        next_st.rdata = {st.shunt, st.cfg}; // see RULE_09
      else
        next_st.rdata = READ_UNMAPPED;
    end
    // the divider setting only reaches the output through the system path
    next_level = src_sys ? cif.level : osc_level; // see RULE_01, RULE_02
    next_st.conv_clk   = next_level;
    next_st.conv_tick  = src_sys ? cif.tick : (osc_level & ~(st.osc_prev & ~st.cfg[CFG_LOCAL_OSC_DISABLE_BIT]));
    next_st.osc_enable = ~st.cfg[CFG_LOCAL_OSC_DISABLE_BIT]; // see RULE_11
    next_st.adc_sync   = sync_on; // see RULE_06
    // quiet interval taken as the low half of the converter period
    next_st.track   = sync_on & ~next_level; // see RULE_06
    next_st.sar_clk = sync_on & (next_level ^ ~st.ctrl[CTRL_POL_BIT]); // see RULE_05
    if (next_st.conv_tick)
      next_st.skip = (mpw != MPW_OFF) && (duty_request < {5'h0, mpw_cycles(mpw)}); // see RULE_08
    next_st.target_cv = vout_cv(st.cfg[CFG_VOUT_HI:CFG_VOUT_LO]); // see RULE_10
    next_st.shunt     = forced_shunt_enable | st.hold_s2; // see RULE_13
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st      <= '0;
      st.ctrl <= CTRL_RESET; // see RULE_14
      st.cfg  <= CFG_RESET; // see RULE_14
    end
    else if (ce)
      st <= next_st;
  end

  assign sfr_rdata          = st.rdata;
  assign conv_clk           = st.conv_clk;
  assign conv_tick          = st.conv_tick;
  assign osc_enable         = st.osc_enable;
  assign adc_sync_enable    = st.adc_sync;
  assign adc_sar_clk        = st.sar_clk;
  assign adc_track_window   = st.track;
  assign pulse_skip         = st.skip;
  assign target_cv          = st.target_cv;
  assign switch_size_select = st.cfg[CFG_SW_HI:CFG_SW_LO];
  assign shunt_close        = st.shunt;

  sequence s_sync_on;
    ce && sync_on;
  endsequence

  sequence s_level_seen;
    ##1 adc_sar_clk == (conv_clk ^ ~$past(st.ctrl[CTRL_POL_BIT]));
  endsequence

  a_src_sys_path: assert property (@(posedge clk) disable iff (rst)
    ce && src_sys |=> conv_clk == $past(cif.level)) // see RULE_01
    else $error("system clock path not routed to converter");
  a_src_osc_path: assert property (@(posedge clk) disable iff (rst)
    ce && !src_sys |=> conv_clk == $past(osc_level)) // see RULE_02
    else $error("local oscillator path not routed to converter");
  a_invert_level: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && $past(st.ctrl[CTRL_INV_BIT]) && $past(cif.div_sel) == 2'h0 |-> cif.level == 1'b0) // see RULE_04
    else $error("inverted divide-by-one level not low");
  a_sar_polarity: assert property (@(posedge clk) disable iff (rst)
    s_sync_on |-> s_level_seen) // see RULE_05
    else $error("SAR clock polarity wrong under sync");
  a_sync_off_quiet: assert property (@(posedge clk) disable iff (rst)
    ce && !sync_on |=> !adc_sar_clk && !adc_track_window && !adc_sync_enable) // see RULE_06
    else $error("ADC sync outputs active with sync off");
  a_track_quiet: assert property (@(posedge clk) disable iff (rst)
    adc_track_window |-> !conv_clk) // see RULE_06
    else $error("tracking outside quiet interval");
  a_skip_off: assert property (@(posedge clk) disable iff (rst)
    ce && next_st.conv_tick && mpw == MPW_OFF |=> !pulse_skip) // see RULE_08
    else $error("pulse skipped with skipping disabled");
  a_skip_short: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && next_st.conv_tick && mpw == MPW_20 && duty_request == 8'h01 |=> pulse_skip) // see RULE_08
    else $error("short pulse not skipped at 20 ns");
  a_status_read: assert property (@(posedge clk) disable iff (rst)
    ce && sfr_rd && hit(sfr_addr, ADDR_CONFIG) |=> sfr_rdata[CFG_SHUNT_BIT] == $past(shunt_close)) // see RULE_09
    else $error("shunt status bit misreports switch");
  a_target_volt: assert property (@(posedge clk) disable iff (rst)
    ce && st.cfg[CFG_VOUT_HI:CFG_VOUT_LO] == 4'h5 |=> target_cv == 9'h0E6) // see RULE_10
    else $error("code 0101 does not give 2.3 V");
  a_osc_stop: assert property (@(posedge clk) disable iff (rst)
    ce && st.cfg[CFG_LOCAL_OSC_DISABLE_BIT] |=> !osc_enable ##0 ($past(src_sys) || !conv_clk)) // see RULE_11
    else $error("local oscillator still running when disabled");
  a_sw_reserved: assert property (@(posedge clk) disable iff (rst)
    switch_size_select == SW_MIN || switch_size_select == SW_MAX) // see RULE_12
    else $error("reserved switch size code taken");
  a_shunt_forced: assert property (@(posedge clk) disable iff (rst)
    ce && forced_shunt_enable |=> shunt_close) // see RULE_13
    else $error("forced shunt did not close switch");
  // no disable here: reset itself is what is being watched
  a_reset_vals: assert property (@(posedge clk)
    rst |=> st.ctrl == CTRL_RESET && st.cfg == CFG_RESET) // see RULE_14
    else $error("register reset values wrong");
endmodule
`default_nettype wire

// ---- include/buck_pkg.sv ----
// Purpose: shared constants for the step-down converter control registers
// Assumes: 100 MHz system clock, 8-bit special-function-register bus
// Notes:   field positions, reset values and timing figures live here only
`default_nettype none
package buck_pkg;
  // register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_CONFIG  = 8'h96;
  localparam logic [7:0] ADDR_CONTROL = 8'h97;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // control register fields
  localparam int CTRL_SRC_BIT  = 7;
  localparam int CTRL_DIV_HI   = 6;
  localparam int CTRL_DIV_LO   = 5;
  localparam int CTRL_POL_BIT  = 4;
  localparam int CTRL_INV_BIT  = 3;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_MPW_HI   = 1;
  localparam int CTRL_MPW_LO   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // configuration register fields
  localparam int CFG_SHUNT_BIT  = 7;
  localparam int CFG_VOUT_HI    = 6;
  localparam int CFG_VOUT_LO    = 3;
  localparam int CFG_LOCAL_OSC_DISABLE_BIT = 2;
  localparam int CFG_SW_HI      = 1;
  localparam int CFG_SW_LO      = 0;
  localparam logic [6:0] CFG_RESET = 7'h0B;

  // field codes
  localparam logic [1:0] MPW_OFF = 2'h0;
  localparam logic [1:0] MPW_10  = 2'h1;
  localparam logic [1:0] MPW_20  = 2'h2;
  localparam logic [1:0] SW_MIN  = 2'h0;
  localparam logic [1:0] SW_MAX  = 2'h3;

  // target output voltage in hundredths of a volt
  localparam logic [8:0] VOUT_BASE_CV = 9'h0B4;
  localparam logic [8:0] VOUT_STEP_CV = 9'h00A;
  localparam logic [3:0] VOUT_TOP_CODE = 4'h7;

  // minimum pulse widths, rounded up to whole system clock cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int MPW1_NS = 10;
  localparam int MPW2_NS = 20;
  localparam int MPW3_NS = 40;
  localparam logic [2:0] MPW1_CYC = 3'((MPW1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] MPW2_CYC = 3'((MPW2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] MPW3_CYC = 3'((MPW3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// ---- include/conv_clk_if.sv ----
// Purpose: carries divider settings and divided clock between control and divider
// Assumes: all signals on the system clock
// Notes:   level and tick are registered in the divider
`default_nettype none
interface conv_clk_if;
  logic       ce;
  logic [1:0] div_sel;
  logic       invert;
  logic       tick;
  logic       level;
  modport gen  (input ce, input div_sel, input invert, output tick, output level);
  modport user (output ce, output div_sel, output invert, input tick, input level);
endinterface
`default_nettype wire

// ---- src/conv_clock_gen.sv ----
// Purpose: divides the system clock by 1, 2, 4 or 8 for the converter
// Assumes: clock enable arrives through the interface
// Notes:   inversion is modelled at cycle resolution as an inverted level
`default_nettype none
module conv_clock_gen
(
  input  wire logic clk,
  input  wire logic rst,
  conv_clk_if.gen   cif
);
  import buck_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
    logic       level;
  } gen_s;

  gen_s st;
  gen_s next_st;
  logic [3:0] div_n;

  assign div_n = 4'h1 << cif.div_sel; // see RULE_03

  // count through one converter period, tick at its start
  always_comb
  begin
    next_st = st;
    if ({1'b0, st.cnt} >= div_n - 4'h1)
      next_st.cnt = 3'h0;
    else
      next_st.cnt = st.cnt + 3'h1;
    next_st.tick = (next_st.cnt == 3'h0);
    // divide by one has no low half at this resolution, so it reads high
    next_st.level = ((div_n == 4'h1) || ({1'b0, next_st.cnt} < (div_n >> 1))) ^ cif.invert; // see RULE_04
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st <= '0;
    else if (cif.ce)
      st <= next_st;
  end

  assign cif.tick  = st.tick;
  assign cif.level = st.level;

  // cycles since the last tick, for the period check
  logic [3:0] gap;
  always_ff @(posedge clk)
  begin
    if (rst)
      gap <= 4'h0;
    else if (cif.ce)
      gap <= st.tick ? 4'h1 : gap + 4'h1;
  end

  a_div_period: assert property (@(posedge clk) disable iff (rst)
    cif.ce && st.tick && $stable(cif.div_sel) && $past(cif.div_sel, 8) == cif.div_sel && gap != 4'h0
      |-> gap == div_n) // see RULE_03
    else $error("converter tick spacing differs from divide ratio");
endmodule
`default_nettype wire

// ---- tb/buck_converter_control_regs_tb.sv ----
// Purpose: self-checking bench for the converter control and configuration registers
// Assumes: outputs settle well before the falling edge, where all stimulus changes
// Notes:   the oscillator pin toggles every 4 cycles, so the local path ticks every 8
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module buck_converter_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import buck_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic       osc_clk_in = 1'b0;
  logic       forced_shunt_enable = 1'b0;
  logic       auto_shunt_hold = 1'b0;
  logic [7:0] duty_request = 8'h00;
  logic       conv_clk, conv_tick, osc_enable, adc_sync_enable, adc_sar_clk;
  logic       adc_track_window, pulse_skip, shunt_close;
  logic [8:0] target_cv;
  logic [1:0] switch_size_select;
  int         mismatches = 0;
  int         n_tests = 0;
  int         ticks, highs, tracks;
  // skip table: width code, requested duty, expected skip
  logic [1:0] pc [6] = '{2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h0};
  logic [7:0] pd [6] = '{8'h03, 8'h04, 8'h00, 8'h01, 8'h01, 8'h00};
  logic       px [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  buck_converter_control_regs u_buck_converter_control_regs
  (
    .clk(clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .osc_clk_in(osc_clk_in),
    .forced_shunt_enable(forced_shunt_enable), .auto_shunt_hold(auto_shunt_hold),
    .duty_request(duty_request), .conv_clk(conv_clk), .conv_tick(conv_tick),
    .osc_enable(osc_enable), .adc_sync_enable(adc_sync_enable), .adc_sar_clk(adc_sar_clk),
    .adc_track_window(adc_track_window), .pulse_skip(pulse_skip), .target_cv(target_cv),
    .switch_size_select(switch_size_select), .shunt_close(shunt_close)
  );

  // 100 MHz system clock
  always #5 clk = ~clk;

  // free-running local oscillator, slow enough to be sampled cleanly
  always
  begin
    repeat (4) @(negedge clk);
    osc_clk_in = ~osc_clk_in;
  end

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  // one-cycle read strobe, data is registered at the read edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK(nm, ex, sfr_rdata)
  endtask

  // counts ticks, high levels and tracking cycles over n cycles
  task automatic measure(input int n);
    ticks = 0;
    highs = 0;
    tracks = 0;
    repeat (n)
    begin
      @(negedge clk);
      ticks += int'(conv_tick);
      highs += int'(conv_clk);
      tracks += int'(adc_track_window);
    end
  endtask

  // bounded wait for the start of a converter period
  // the first two cycles let a fresh control write reach the outputs
  task automatic to_tick();
    repeat (2) @(negedge clk);
    for (int i = 0; i < 16 && conv_tick !== 1'b1; i++)
      @(negedge clk);
    if (conv_tick !== 1'b1)
      mismatches++;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: the sequence needs a few thousand cycles at most
  initial
  begin
    #200000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    `CHK("target_cv", 9'h0BE, target_cv)
    `CHK("switch_size", 2'h3, switch_size_select)
    rd_chk(ADDR_CONTROL, 8'h03, "ctrl_reset");
    rd_chk(ADDR_CONFIG, 8'h0B, "cfg_reset");
    rd_chk(8'h55, 8'h00, "unmapped");
    // local oscillator path ignores the divide field
    wr(ADDR_CONTROL, 8'h60);
    repeat (8) @(negedge clk);
    measure(64);
    `CHK("osc_ticks", 8, ticks)
    wr(ADDR_CONFIG, 8'h0F);
    repeat (8) @(negedge clk);
    measure(64);
    `CHK("osc_stopped", 0, ticks)
    `CHK("osc_enable", 1'b0, osc_enable)
    wr(ADDR_CONFIG, 8'h0B);
    // every divide code on the system clock path
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CONTROL, 8'h80 | 8'(k << 5));
      repeat (4) @(negedge clk);
      measure(64);
      `CHK("div_ticks", 64 >> k, ticks)
      `CHK("div_highs", (k == 0) ? 64 : 32, highs)
    end
    // divider input inversion flips the level at the period start
    wr(ADDR_CONTROL, 8'hA0);
    to_tick();
    `CHK("plain_level", 1'b1, conv_clk)
    wr(ADDR_CONTROL, 8'hA8);
    to_tick();
    `CHK("inv_level", 1'b0, conv_clk)
    // inverted divide-by-one has no high cycle at this resolution
    wr(ADDR_CONTROL, 8'h88);
    repeat (4) @(negedge clk);
    measure(64);
    `CHK("inv_div1_highs", 0, highs)
    // synchronised ADC with each polarity, then unsynchronised
    // the bench has no SAR divider of its own, so it counts as already cleared
    wr(ADDR_CONTROL, 8'hA4);
    repeat (2) @(negedge clk);
    measure(64);
    `CHK("track_cycles", 32, tracks)
    `CHK("sync_en", 1'b1, adc_sync_enable)
    to_tick();
    `CHK("sar_inverted", 1'b0, adc_sar_clk)
    wr(ADDR_CONTROL, 8'hB4);
    to_tick();
    `CHK("sar_polarity", 1'b1, adc_sar_clk)
    wr(ADDR_CONTROL, 8'hB0);
    repeat (2) @(negedge clk);
    measure(64);
    `CHK("track_off", 0, tracks)
    `CHK("sar_off", 1'b0, adc_sar_clk)
    // pulse skipping at each width code, on both sides of the limit at 10 and 40 ns
    for (int k = 0; k < 6; k++)
    begin
      duty_request = pd[k];
      wr(ADDR_CONTROL, {6'h38, pc[k]});
      repeat (20) @(negedge clk);
      `CHK("pulse_skip", px[k], pulse_skip)
    end
    // output voltage codes, codes past 0111 stay at the top value
    for (int k = 0; k < 9; k++)
    begin
      wr(ADDR_CONFIG, {1'b0, 4'(k), 3'h3});
      repeat (2) @(negedge clk);
      `CHK("target_cv", 9'(180 + 10 * ((k > 7) ? 7 : k)), target_cv)
    end
    // reserved switch sizes are dropped, bits 6 to 2 of the byte land
    wr(ADDR_CONFIG, 8'h09);
    rd_chk(ADDR_CONFIG, 8'h0B, "sw_rsvd1");
    wr(ADDR_CONFIG, 8'h12);
    rd_chk(ADDR_CONFIG, 8'h13, "sw_rsvd2");
    wr(ADDR_CONFIG, 8'h88);
    rd_chk(ADDR_CONFIG, 8'h08, "sw_min_bit7");
    `CHK("switch_size", 2'h0, switch_size_select)
    // forced and automatic shunt
    forced_shunt_enable = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("forced_shunt", 1'b1, shunt_close)
    rd_chk(ADDR_CONFIG, 8'h88, "shunt_status");
    forced_shunt_enable = 1'b0;
    auto_shunt_hold = 1'b1;
    repeat (5) @(negedge clk);
    `CHK("auto_shunt", 1'b1, shunt_close)
    auto_shunt_hold = 1'b0;
    repeat (5) @(negedge clk);
    `CHK("shunt_open", 1'b0, shunt_close)
    rd_chk(ADDR_CONFIG, 8'h08, "shunt_clear");
    // writes are ignored while the clock enable is low
    ce = 1'b0;
    wr(ADDR_CONFIG, 8'h30);
    ce = 1'b1;
    rd_chk(ADDR_CONFIG, 8'h08, "ce_hold");
    // reset in mid-run restores both registers
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd_chk(ADDR_CONTROL, 8'h03, "ctrl_rereset");
    rd_chk(ADDR_CONFIG, 8'h0B, "cfg_rereset");
    close_out();
  end
endmodule
`default_nettype wire
